// ---- rtl/abw_master.sv ----
// bus master sequencer: write cycles and locked read-modify-write
`timescale 1ns/10ps
// Operation
// - S0 drives address, space, direction low, size
// - operand start joins external start on first
// - address strobe asserted in S1
// - buffer enable asserted in S1 on writes
// - both start strobes negated in S1
// - write data driven from S2
// - size acknowledges sampled at end of S2
// - data strobe asserted in S3 on writes
// - acknowledge by S2 ends cycle a clock and a half later
// - no acknowledge inserts waits, resampling each fall
// - S4 changes no control signal
// - S5 negates strobes, holds everything else valid
// - lock held across whole read-modify-write sequence
// - no bus grant during locked sequence
// - only three atomic ops; failed compares skip writes
// - lock asserted from S0 of first read
// - direction read until S8, data from S10; until S14, data from S16 for dual compare-and-swap
module abw_master (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire abw_pkg::abw_op_t cmd_op,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_addr2,
  input wire logic [2:0] cmd_space,
  input wire logic [1:0] cmd_size,
  input wire logic [31:0] cmd_data,
  input wire logic [31:0] cmd_data2,
  input wire logic [31:0] cmd_cmp,
  input wire logic [31:0] cmd_cmp2,
  output logic cmd_ready,
  output logic op_done,
  output logic op_cmp_fail,
  output logic [31:0] op_rd_data,
  output logic bus_clk,
  output logic [31:0] addr,
  output logic [2:0] space_code,
  output logic xfer_size_hi,
  output logic xfer_size_lo,
  output logic rw_n,
  output logic ext_cycle_start_n,
  output logic operand_cycle_start_n,
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic data_buf_enable_n,
  output logic [31:0] data_out,
  output logic data_oe,
  input wire logic [31:0] data_in,
  input wire logic [1:0] size_ack_n,
  output logic locked_cycle_n,
  input wire logic bus_req_n,
  output logic bus_grant_out_n
);
  import abw_pkg::*;

  typedef struct packed {
    abw_state_t st;
    abw_op_t op;
    logic rd;
    logic idx;
    logic first;
    logic [1:0] gap;
    logic ack_rel;
    logic [31:0] a0;
    logic [31:0] a1;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [31:0] r0;
    logic [2:0] space;
    logic [1:0] size;
    logic ready;
    logic done;
    logic fail;
    logic [31:0] rd_data;
    logic bclk;
    logic [31:0] addr;
    logic rw_n;
    logic ecs_n;
    logic ocs_n;
    logic as_n;
    logic ds_n;
    logic data_buf_enable_n_n;
    logic [31:0] dout;
    logic oe;
    logic lock_n;
    logic grant_n;
  } abw_regs_t;

  localparam abw_regs_t ABW_REGS_RST = '{
    st: ABW_IDLE, op: ABW_OP_WRITE, rd: 1'b0, idx: 1'b0, first: 1'b0,
    gap: 2'h0, ack_rel: 1'b1, a0: ABW_ADDR_RST, a1: ABW_ADDR_RST,
    w0: ABW_DATA_RST, w1: ABW_DATA_RST, c0: ABW_DATA_RST, c1: ABW_DATA_RST,
    r0: ABW_DATA_RST, space: ABW_SPACE_RST, size: ABW_SIZE_RST,
    ready: 1'b0, done: 1'b0, fail: 1'b0, rd_data: ABW_DATA_RST,
    bclk: 1'b0, addr: ABW_ADDR_RST, rw_n: 1'b1, ecs_n: 1'b1,
    ocs_n: 1'b1, as_n: 1'b1, ds_n: 1'b1, data_buf_enable_n_n: 1'b1,
    dout: ABW_DATA_RST, oe: 1'b0, lock_n: 1'b1, grant_n: 1'b1
  };

  abw_regs_t q;
  abw_regs_t d;
  logic [2:0] sync_out;
  logic [1:0] ack_n;
  logic req_n;

  abw_sync #(
    .W(ABW_SYNC_W),
    .RST_VAL(ABW_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({bus_req_n, size_ack_n}),
    .dout(sync_out)
  );

  assign ack_n = sync_out[1:0];
  assign req_n = sync_out[2];

  // test-and-set sets the top bit of the addressed byte lane
  function automatic logic [31:0] tas_value(input logic [31:0] v,
                                            input logic [1:0] a);
    logic [31:0] r;
    r = v;
    r[{~a, 3'h0} + 5'(ABW_TAS_BIT)] = 1'b1;
    return r;
  endfunction : tas_value

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.bclk = ~q.bclk;
    // sync lag lets the last ack linger; it counts only after a release
    d.ack_rel = q.ack_rel || (ack_n == ABW_ACK_NONE);
    case (q.st)
      ABW_IDLE: begin
        d.grant_n = req_n;
        if (cmd_valid && q.ready) begin
          d.st = ABW_S0;
          d.op = cmd_op;
          d.rd = (cmd_op != ABW_OP_WRITE);
          d.idx = 1'b0;
          d.first = 1'b1;
          d.a0 = cmd_addr;
          d.a1 = cmd_addr2;
          d.w0 = cmd_data;
          d.w1 = cmd_data2;
          d.c0 = cmd_cmp;
          d.c1 = cmd_cmp2;
          d.space = cmd_space;
          d.size = cmd_size;
          d.fail = 1'b0;
          d.grant_n = 1'b1;
        end
      end
      ABW_S0: d.st = ABW_S1;
      ABW_S1: begin
        d.st = ABW_S2;
        d.first = 1'b0;
      end
      ABW_S2: begin
        // end of S2 is a falling bus edge
        if (q.ack_rel && ack_n != ABW_ACK_NONE) begin
          d.st = ABW_S3;
        end else begin
          d.st = ABW_SW0;
        end
      end
      ABW_SW0: d.st = ABW_SW1;
      ABW_SW1: begin
        if (q.ack_rel && ack_n != ABW_ACK_NONE) begin
          d.st = ABW_S3;
        end else begin
          d.st = ABW_SW0;
        end
      end
      ABW_S3: d.st = ABW_S4;
      ABW_S4: begin
        d.st = ABW_S5;
        if (q.rd) begin
          if (q.idx) begin
            d.rd_data = data_in;
          end else begin
            d.r0 = data_in;
            d.rd_data = data_in;
          end
        end
      end
      ABW_S5: begin
        if (q.op == ABW_OP_DUAL_CMP_SWAP && !q.idx) begin
          d.idx = 1'b1;
          d.st = ABW_S0;
        end else if (q.rd) begin
          d.idx = 1'b0;
          d.gap = ABW_GAP_STATES;
          d.st = ABW_GAP;
          case (q.op)
            ABW_OP_TEST_SET: d.w0 = tas_value(q.r0, q.a0[1:0]);
            ABW_OP_CMP_SWAP: d.fail = (q.r0 != q.c0);
            default: d.fail = (q.r0 != q.c0) || (q.rd_data != q.c1);
          endcase
          if (d.fail) begin
            d.st = ABW_IDLE;
            d.done = 1'b1;
          end
        end else begin
          d.st = ABW_IDLE;
          d.done = 1'b1;
        end
      end
      ABW_GAP: begin
        d.gap = q.gap - 2'h1;
        if (q.gap == 2'h1) begin
          d.st = ABW_S0;
          d.rd = 1'b0;
          d.first = 1'b1;
        end
      end
      default: d.st = ABW_IDLE;
    endcase

    // cycle-level outputs follow the next state
    if (d.st == ABW_S0 && q.st != ABW_S0) begin
      d.addr = d.idx ? d.a1 : d.a0;
      d.rw_n = d.rd;
      d.lock_n = (d.op == ABW_OP_WRITE);
      d.ack_rel = (ack_n == ABW_ACK_NONE);
    end
    if (d.st == ABW_IDLE) begin
      d.lock_n = 1'b1;
    end
    d.ecs_n = (d.st != ABW_S0);
    d.ocs_n = !(d.st == ABW_S0 && d.first);
    // S4 repeats S3 and wait states repeat S2 for every strobe
    d.as_n = !(d.st inside {ABW_S1, ABW_S2, ABW_SW0, ABW_SW1, ABW_S3,
                           ABW_S4});
    if (d.rd) begin
      d.ds_n = d.as_n;
      d.data_buf_enable_n_n = !(d.st inside {ABW_S2, ABW_SW0, ABW_SW1, ABW_S3,
                               ABW_S4});
      d.oe = 1'b0;
    end else begin
      d.ds_n = !(d.st inside {ABW_S3, ABW_S4});
      d.data_buf_enable_n_n = !(d.st inside {ABW_S1, ABW_S2, ABW_SW0, ABW_SW1,
                               ABW_S3, ABW_S4, ABW_S5});
      // held through S5 for data hold time
      d.oe = (d.st inside {ABW_S2, ABW_SW0, ABW_SW1, ABW_S3, ABW_S4,
                          ABW_S5});
    end
    d.dout = d.oe ? (d.idx ? d.w1 : d.w0) : q.dout;
    if (d.st != ABW_IDLE) begin
      d.grant_n = 1'b1;
    end
    // start only on a rising bus edge, never while another master holds
    d.ready = (d.st == ABW_IDLE) && !d.bclk && d.grant_n && req_n;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= ABW_REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready = q.ready;
  assign op_done = q.done;
  assign op_cmp_fail = q.fail;
  assign op_rd_data = q.rd_data;
  assign bus_clk = q.bclk;
  assign addr = q.addr;
  assign space_code = q.space;
  assign xfer_size_hi = q.size[1];
  assign xfer_size_lo = q.size[0];
  assign rw_n = q.rw_n;
  assign ext_cycle_start_n = q.ecs_n;
  assign operand_cycle_start_n = q.ocs_n;
  assign addr_strobe_n = q.as_n;
  assign data_strobe_n = q.ds_n;
  assign data_buf_enable_n = q.data_buf_enable_n_n;
  assign data_out = q.dout;
  assign data_oe = q.oe;
  assign locked_cycle_n = q.lock_n;
  assign bus_grant_out_n = q.grant_n;
endmodule : abw_master

// ---- rtl/abw_pkg.sv ----
// constants and types shared by the asynchronous bus write sequencer
package abw_pkg;

  // operation kinds presented on the command port
  typedef enum logic [1:0] {
    ABW_OP_WRITE = 2'h0,
    ABW_OP_TEST_SET = 2'h1,
    ABW_OP_CMP_SWAP = 2'h2,
    ABW_OP_DUAL_CMP_SWAP = 2'h3
  } abw_op_t;

  // bus states, one per half bus clock; gray along idle-S0..S5-gap-wait
  typedef enum logic [3:0] {
    ABW_IDLE = 4'h0,
    ABW_S0 = 4'h1,
    ABW_S1 = 4'h3,
    ABW_S2 = 4'h2,
    ABW_S3 = 4'h6,
    ABW_S4 = 4'h7,
    ABW_S5 = 4'h5,
    ABW_GAP = 4'h4,
    ABW_SW0 = 4'hC,
    ABW_SW1 = 4'hD
  } abw_state_t;

  localparam int ABW_SYNC_W = 3;
  localparam logic [2:0] ABW_SYNC_RST = 3'h7;
  localparam logic [1:0] ABW_ACK_NONE = 2'h3;
  localparam logic [31:0] ABW_DATA_RST = 32'h0;
  localparam logic [31:0] ABW_ADDR_RST = 32'h0;
  localparam logic [2:0] ABW_SPACE_RST = 3'h0;
  localparam logic [1:0] ABW_SIZE_RST = 2'h0;
  // bit of a byte lane set by test-and-set
  localparam int ABW_TAS_BIT = 7;
  // idle half-states between the read and write portions
  localparam logic [1:0] ABW_GAP_STATES = 2'h2;

endpackage : abw_pkg

// ---- rtl/abw_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module abw_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : abw_sync

// ---- tb/abw_master_sva.sv ----
// port assertions for the bus master sequencer
`timescale 1ns/10ps
module abw_master_sva (
  input logic clk,
  input logic rst,
  input logic bus_clk,
  input logic rw_n,
  input logic ext_cycle_start_n,
  input logic operand_cycle_start_n,
  input logic addr_strobe_n,
  input logic data_strobe_n,
  input logic data_buf_enable_n,
  input logic data_oe,
  input logic [31:0] addr,
  input logic [31:0] data_out,
  input logic locked_cycle_n,
  input logic bus_grant_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  s0_write_a: assert property (
    $fell(ext_cycle_start_n) && locked_cycle_n |->
    !rw_n && !operand_cycle_start_n) else $error("s0 bad");
  s1_strobes_a: assert property (
    $fell(ext_cycle_start_n) |=> $fell(addr_strobe_n) &&
    ext_cycle_start_n && operand_cycle_start_n) else $error("s1 bad");
  data_buf_enable_n_s1_a: assert property (
    $fell(addr_strobe_n) && !rw_n |-> !data_buf_enable_n)
    else $error("data_buf_enable_n bad");
  data_s2_a: assert property (
    $fell(ext_cycle_start_n) && !rw_n |-> ##2 data_oe && data_strobe_n)
    else $error("s2 bad");
  s4_quiet_a: assert property (
    $fell(data_strobe_n) && !rw_n |-> data_oe ##1
    $stable({addr_strobe_n, data_strobe_n, data_buf_enable_n, data_out}))
    else $error("s4 bad");
  s5_release_a: assert property (
    $rose(addr_strobe_n) && !rw_n |-> $rose(data_strobe_n) &&
    $stable(addr) && data_oe && !data_buf_enable_n) else $error("s5 bad");
  lock_grant_a: assert property (
    !locked_cycle_n |-> bus_grant_out_n) else $error("grant in lock");
  rmw_dir_a: assert property (
    $fell(rw_n) && !locked_cycle_n |-> $fell(ext_cycle_start_n))
    else $error("rmw dir bad");
  bclk_toggle_a: assert property (
    !$past(rst) |-> $changed(bus_clk)) else $error("bus clock stuck");
  start_rise_a: assert property (
    $fell(ext_cycle_start_n) |-> bus_clk) else $error("start off edge");
  lock_start_a: assert property (
    $fell(locked_cycle_n) |-> $fell(ext_cycle_start_n) && rw_n)
    else $error("lock start bad");
endmodule : abw_master_sva
bind abw_master abw_master_sva i_sva (.*);

// ---- tb/abw_slave.sv ----
// behavioural memory slave on the asynchronous bus
`timescale 1ns/10ps
module abw_slave (
  input logic clk,
  input logic rst,
  input logic [31:0] addr,
  input logic rw_n,
  input logic addr_strobe_n,
  input logic data_strobe_n,
  input logic xfer_size_hi,
  input logic xfer_size_lo,
  input logic [31:0] data_out,
  input int wait_cyc,
  output logic [31:0] data_in,
  output logic [1:0] size_ack_n
);
  logic [31:0] mem [16];
  logic [31:0] idle_q;
  logic ack_q;
  int cnt;
  wire [3:0] idx = addr[5:2];
  wire [4:0] sh = {~addr[1:0], 3'h0};
  // released lines show a toggling pattern, not the last word
  assign data_in = (!addr_strobe_n && rw_n) ? mem[idx] : idle_q;
  // ack drops as soon as the strobe goes, so no stale ack meets the next S2
  assign size_ack_n = (ack_q && !addr_strobe_n) ? 2'h0 : 2'h3;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      cnt <= 0;
      idle_q <= 32'h5A5A5A5A;
    end else begin
      idle_q <= ~idle_q;
      cnt <= addr_strobe_n ? 0 : cnt + 1;
      if (addr_strobe_n) begin
        ack_q <= 1'b0;
      end else if (cnt >= wait_cyc) begin
        ack_q <= 1'b1;
      end
      if (!addr_strobe_n && !rw_n && !data_strobe_n) begin
        if ({xfer_size_hi, xfer_size_lo} == 2'h1) begin
          mem[idx][sh+:8] <= data_out[sh+:8];
        end else begin
          mem[idx] <= data_out;
        end
      end
    end
  end
endmodule : abw_slave

// ---- tb/abw_master_bench.sv ----
// self-checking bench for the bus master sequencer
`timescale 1ns/10ps
module abw_master_bench;
  import abw_pkg::*;
  logic clk = 0, rst = 1, cmd_valid = 0, bus_req_n = 1, lk_hi, req_mid = 0;
  abw_op_t cmd_op = ABW_OP_WRITE;
  logic [31:0] cmd_addr = '0, cmd_addr2 = '0, cmd_data = '0, cmd_data2 = '0;
  logic [31:0] cmd_cmp = '0, cmd_cmp2 = '0, addr, data_out, data_in;
  logic [31:0] op_rd_data;
  logic [2:0] cmd_space = 3'h5, space_code;
  logic [1:0] cmd_size = 2'h0, size_ack_n;
  logic cmd_ready, op_done, op_cmp_fail, bus_clk, xfer_size_hi, xfer_size_lo;
  logic rw_n, ext_cycle_start_n, operand_cycle_start_n, addr_strobe_n;
  logic data_strobe_n, data_buf_enable_n, data_oe, locked_cycle_n;
  logic bus_grant_out_n;
  int num_errors = 0, check_count = 0, wait_cyc = 0, n, n0;
  always #2 clk = ~clk;
  abw_master i_dut (.*);
  abw_slave i_slave (.*);
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic run(input abw_op_t op, input logic [31:0] a, a2, d, d2, c,
                     c2);
    cmd_op = op;
    {cmd_addr, cmd_addr2, cmd_data, cmd_data2, cmd_cmp, cmd_cmp2} =
      {a, a2, d, d2, c, c2};
    for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) tick();
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    chk(addr, a);
    chk(32'(space_code), 32'(cmd_space));
    chk(32'({xfer_size_hi, xfer_size_lo}), 32'(cmd_size));
    chk(32'(rw_n), 32'(op != ABW_OP_WRITE));
    chk(32'(locked_cycle_n), 32'(op == ABW_OP_WRITE));
    chk(32'({ext_cycle_start_n, operand_cycle_start_n}), 32'h0);
    chk(32'(bus_clk), 32'h1);
    lk_hi = 1'b0;
    for (n = 0; n < 300 && op_done !== 1'b1; n++) begin
      if (n == 2 && req_mid) bus_req_n = 1'b0;
      tick();
      if (op_done !== 1'b1) lk_hi = lk_hi | (locked_cycle_n !== 1'b0);
    end
    chk(32'(op_done), 32'h1);
    if (op != ABW_OP_WRITE) chk(32'(lk_hi), 32'h0);
    tick();
    chk(32'(op_done), 32'h0);
  endtask : run
  task automatic t_write;
    run(ABW_OP_WRITE, 32'h10, 0, 32'hA5A50001, 0, 0, 0);
    chk(i_slave.mem[4], 32'hA5A50001);
    n0 = n;
    wait_cyc = 9;
    run(ABW_OP_WRITE, 32'h14, 0, 32'h12345678, 0, 0, 0);
    chk(i_slave.mem[5], 32'h12345678);
    chk(32'(n - n0), 32'hA);
    wait_cyc = 0;
    cmd_size = 2'h1;
    i_slave.mem[6] = 32'h11111111;
    run(ABW_OP_WRITE, 32'h1B, 0, 32'h000000C3, 0, 0, 0);
    chk(i_slave.mem[6], 32'h111111C3);
  endtask : t_write
  task automatic t_rmw;
    i_slave.mem[8] = 32'h12003400;
    run(ABW_OP_TEST_SET, 32'h21, 0, 0, 0, 0, 0);
    chk(op_rd_data, 32'h12003400);
    chk(i_slave.mem[8], 32'h12803400);
    cmd_size = 2'h0;
    i_slave.mem[12] = 32'h1;
    run(ABW_OP_CMP_SWAP, 32'h30, 0, 32'h9, 0, 32'h2, 0);
    chk(32'(op_cmp_fail), 32'h1);
    chk(i_slave.mem[12], 32'h1);
    i_slave.mem[13] = 32'h3;
    i_slave.mem[14] = 32'h4;
    req_mid = 1'b1;
    run(ABW_OP_DUAL_CMP_SWAP, 32'h34, 32'h38, 32'h5, 32'h6, 32'h3, 32'h4);
    chk(32'(op_cmp_fail), 32'h0);
    chk({i_slave.mem[13][15:0], i_slave.mem[14][15:0]}, 32'h50006);
  endtask : t_rmw
  task automatic t_grant;
    for (n = 0; n < 12 && bus_grant_out_n !== 1'b0; n++) tick();
    chk(32'(bus_grant_out_n), 32'h0);
    chk(32'(cmd_ready), 32'h0);
    bus_req_n = 1'b1;
    for (n = 0; n < 12 && bus_grant_out_n !== 1'b1; n++) tick();
    chk(32'(bus_grant_out_n), 32'h1);
  endtask : t_grant
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    tick();
    t_write();
    t_rmw();
    t_grant();
    wrap_up();
  end
  initial begin
    #40000;
    num_errors++;
    wrap_up();
  end
endmodule : abw_master_bench
